// ==== power_path_defines.svh ====
// Purpose: Constants for the power path mode control block.
// Assumes: 100 MHz clock; register port with one-cycle read latency.
// Notes:   Offsets are byte addresses of 32-bit words.
// Functional notes
// - Input sag to threshold limits input current and sets input-limit status.
// - Double timer enable extends safety timer while input limiting active.
// - No charge termination while input-voltage limiting active.
// - Low system rail cuts charge current before battery is drawn.
// - Termination blocked while headroom loop is in control.
// - Zero charge current and rail below supplement threshold enters supplement.
// - Headroom disable bit allows low headroom; no effect in battery tracking.
// - Termination disabled during supplement; overcurrent protection stays active.
// - Battery supplements only when above undervoltage threshold.
// - Mode 00 normal, 01 battery, 10 off floating, 11 off pulled down.
// - Mode resets to normal; rail from input if valid else battery.
// - Battery mode ignored below battery lockout; input re-plug reverts normal.
// - Forcing battery mode while charging stops charging.
// - Floating-off disconnects rail without pulldown; input cycling returns normal.
// - Pulldown-off disconnects and grounds rail; input toggle returns normal.
// - Ship mode pulldown only after battery switch opens.
// - Hardware reset pulldown after both switches open, held until wake timer.
// - Pulldown-off pulldown after switches open, held until mode write or toggle.
// - System regulation only with input valid, above battery, below overvoltage.
// - Regulation 000 tracks battery, 001-110 fixed 4.4-4.9 V, 111 pass-through.
// - Current-limit clamp active sets current-limit status bit.
// - Current-limit mask only gates its interrupt; limit rewritable anytime.
`ifndef POWER_PATH_DEFINES_SVH
`define POWER_PATH_DEFINES_SVH
`define PP_CTRL_OFS      8'h00
`define PP_STAT_OFS      8'h04
`define PP_INPUT_CURRENT_LIMIT_OFS      8'h08
`define PP_MODE_LSB      0
`define PP_REG_LSB       2
`define PP_HEADDIS_BIT   5
`define PP_DBLTMR_BIT    6
`define PP_MASK_BIT      7
`define PP_MODE_RST      2'h0
`define PP_REG_RST       3'h2
`define PP_INPUT_CURRENT_LIMIT_RST      8'h00
`define PP_DGL_NS        64000
`define PP_CLK_NS        10
`define PP_DGL_CYC       (`PP_DGL_NS / `PP_CLK_NS)
`endif

// ==== power_path_pkg.sv ====
// Purpose: Types for the power path mode control block.
// Assumes: Constants live in power_path_defines.svh.
// Notes:   Nothing here is imported; use package scope.
package power_path_pkg;
    typedef enum logic [1:0] {
        SUPPLY_NORMAL   = 2'h0,
        SUPPLY_BATTERY  = 2'h1,
        SUPPLY_FLOAT    = 2'h2,
        SUPPLY_PULLDOWN = 2'h3
    } supply_mode_t;
    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_OPEN,
        SEQ_PULL
    } off_seq_t;
endpackage : power_path_pkg

// ==== input_toggle_detect.sv ====
// Purpose: Synchronise and deglitch input-valid levels, report re-plug events.
// Assumes: Raw levels may be asynchronous to clk.
// Notes:   A level must hold DGL_CYC cycles before it is accepted.
`timescale 1ns/1ps
module input_toggle_detect #(
    parameter int DGL_CYC = 6400
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rstn,
    // Raw level.
    input  wire logic in_valid_raw,
    // Filtered results.
    output logic      in_valid_q,
    output logic      toggle_pulse_q
);
    logic        s1_q;
    logic        s2_q;
    logic        seen_low_q;
    logic [31:0] cnt_q;

    // Two-flop synchroniser; only the second flop is looked at.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            s1_q <= in_valid_raw;
            s2_q <= s1_q;
        end
    end

    // Deglitch counter restarts whenever the level disagrees briefly.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q      <= 32'h0;
            in_valid_q <= 1'b0;
        end else if (s2_q == in_valid_q) begin
            cnt_q <= 32'h0;
        end else if (cnt_q >= 32'(DGL_CYC - 1)) begin
            cnt_q      <= 32'h0;
            in_valid_q <= s2_q;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    // A toggle is a filtered fall followed by a filtered rise.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seen_low_q     <= 1'b0;
            toggle_pulse_q <= 1'b0;
        end else begin
            toggle_pulse_q <= 1'b0;
            if (in_valid_q && (cnt_q >= 32'(DGL_CYC - 1)) && (s2_q != in_valid_q)) begin
                seen_low_q <= 1'b1;
            end else if (!in_valid_q && (cnt_q >= 32'(DGL_CYC - 1)) && s2_q) begin
                toggle_pulse_q <= seen_low_q;
                seen_low_q     <= 1'b0;
            end
        end
    end
endmodule : input_toggle_detect

// ==== power_path_ctrl.sv ====
// Purpose: Power path mode control: limit loops, supplement, supply select, pulldown.
// Assumes: Comparator levels other than in_valid_raw arrive synchronous to clk; register reads have one-cycle latency.
// Notes:   Analog loops are outside; this block only decides and reports.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "power_path_defines.svh"
module power_path_ctrl #(
    parameter int DGL_CYC = `PP_DGL_CYC
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rstn,
    // Register port.
    input  wire logic [7:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [31:0]     rdata,
    // Analog comparator levels.
    input  wire logic       in_valid_raw,
    input  wire logic       in_above_limit,
    input  wire logic       in_above_bat,
    input  wire logic       in_below_ovp,
    input  wire logic       sys_below_headroom,
    input  wire logic       sys_below_supplement,
    input  wire logic       bat_above_uvlo,
    input  wire logic       input_current_limit_clamp,
    input  wire logic       charge_current_zero,
    input  wire logic       charging,
    input  wire logic       ship_req,
    input  wire logic       hardware_reset_state_req,
    input  wire logic       wake_expired,
    input  wire logic       bat_switch_open,
    input  wire logic       in_switch_open,
    // Control outputs.
    output logic            in_current_reduce_q,
    output logic            charge_cut_q,
    output logic            term_block_q,
    output logic            timer_extend_q,
    output logic            supplement_q,
    output logic            charge_stop_q,
    output logic            sys_from_in_q,
    output logic            sys_from_bat_q,
    output logic            bat_switch_open_req_q,
    output logic            in_switch_open_req_q,
    output logic            pulldown_q,
    output logic            sys_reg_en_q,
    output logic [2:0]      reg_target_q,
    output logic [7:0]      input_current_limit_code_q,
    output logic            input_current_limit_irq_q
);
    power_path_pkg::supply_mode_t mode_q;
    power_path_pkg::off_seq_t     seq_q;
    logic       head_dis_q;
    logic       dbl_tmr_q;
    logic       input_current_limit_mask_q;
    logic       vin_limit_flag_q;
    logic       input_current_limit_flag_q;
    logic       input_current_limit_prev_q;
    logic       in_valid_q;
    logic       toggle_q;
    logic       vin_limit_on;
    logic       head_on;
    logic       in_good;
    logic       ctrl_wr;
    logic       pd_cond;
    logic       reset_hold_q;

    input_toggle_detect #(
        .DGL_CYC        (DGL_CYC)
    ) u_toggle (
        .clk            (clk),
        .rstn           (rstn),
        .in_valid_raw   (in_valid_raw),
        .in_valid_q     (in_valid_q),
        .toggle_pulse_q (toggle_q)
    );

    // Loop activity, derived combinationally from comparators and settings.
    assign vin_limit_on = in_valid_q && !in_above_limit;
    // Tracking target already sits above the headroom level, so the disable bit is moot there.
    assign head_on = sys_below_headroom &&
                     (!head_dis_q || (reg_target_q == 3'h0));
    assign in_good = in_valid_q && in_above_bat && in_below_ovp;
    assign ctrl_wr = wr && (addr == `PP_CTRL_OFS);

    // Software settings; the limit code may be rewritten at any time.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_target_q <= `PP_REG_RST;
            head_dis_q   <= 1'b0;
            dbl_tmr_q    <= 1'b0;
            input_current_limit_mask_q  <= 1'b0;
            input_current_limit_code_q  <= `PP_INPUT_CURRENT_LIMIT_RST;
        end else begin
            if (ctrl_wr) begin
                reg_target_q <= wdata[`PP_REG_LSB +: 3];
                head_dis_q   <= wdata[`PP_HEADDIS_BIT];
                dbl_tmr_q    <= wdata[`PP_DBLTMR_BIT];
                input_current_limit_mask_q  <= wdata[`PP_MASK_BIT];
            end
            if (wr && (addr == `PP_INPUT_CURRENT_LIMIT_OFS)) begin
                input_current_limit_code_q <= wdata[7:0];
            end
        end
    end

    // Supply mode: input toggle beats a same-cycle write, so a re-plug always restores normal mode.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= power_path_pkg::SUPPLY_NORMAL;
        end else if (toggle_q) begin
            mode_q <= power_path_pkg::SUPPLY_NORMAL;
        end else if (ctrl_wr) begin
            if ((wdata[`PP_MODE_LSB +: 2] == 2'h1) && !bat_above_uvlo) begin
                mode_q <= power_path_pkg::SUPPLY_NORMAL;
            end else begin
                mode_q <= power_path_pkg::supply_mode_t'(wdata[`PP_MODE_LSB +: 2]);
            end
        end else if ((mode_q == power_path_pkg::SUPPLY_BATTERY) && !bat_above_uvlo) begin
            mode_q <= power_path_pkg::SUPPLY_NORMAL;
        end
    end

    // Loop outputs and supplement state.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            in_current_reduce_q <= 1'b0;
            charge_cut_q        <= 1'b0;
            term_block_q        <= 1'b0;
            timer_extend_q      <= 1'b0;
            supplement_q        <= 1'b0;
            charge_stop_q       <= 1'b0;
            sys_reg_en_q        <= 1'b0;
        end else begin
            in_current_reduce_q <= vin_limit_on;
            timer_extend_q      <= dbl_tmr_q && vin_limit_on;
            charge_cut_q        <= head_on;
            // Supplement needs the charge current already cut and a healthy battery.
            supplement_q        <= charge_current_zero && sys_below_supplement
                                   && bat_above_uvlo;
            term_block_q        <= vin_limit_on || head_on || supplement_q;
            charge_stop_q       <= charging && (mode_q == power_path_pkg::SUPPLY_BATTERY);
            sys_reg_en_q        <= in_good;
        end
    end

    // Path selection per mode; battery feed still honours the lockout.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sys_from_in_q  <= 1'b0;
            sys_from_bat_q <= 1'b0;
        end else begin
            unique case (mode_q)
                power_path_pkg::SUPPLY_NORMAL: begin
                    sys_from_in_q  <= in_good && (seq_q == power_path_pkg::SEQ_IDLE);
                    sys_from_bat_q <= !in_good && bat_above_uvlo &&
                                      (seq_q == power_path_pkg::SEQ_IDLE);
                end
                power_path_pkg::SUPPLY_BATTERY: begin
                    sys_from_in_q  <= 1'b0;
                    sys_from_bat_q <= bat_above_uvlo && (seq_q == power_path_pkg::SEQ_IDLE);
                end
                power_path_pkg::SUPPLY_FLOAT, power_path_pkg::SUPPLY_PULLDOWN: begin
                    sys_from_in_q  <= 1'b0;
                    sys_from_bat_q <= 1'b0;
                end
            endcase
        end
    end

    // Rail-off sequence: open switches first, then pull down once they report open.
    assign pd_cond = ship_req || hardware_reset_state_req || (mode_q == power_path_pkg::SUPPLY_PULLDOWN);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seq_q                 <= power_path_pkg::SEQ_IDLE;
            bat_switch_open_req_q <= 1'b0;
            in_switch_open_req_q  <= 1'b0;
            pulldown_q            <= 1'b0;
        end else begin
            unique case (seq_q)
                power_path_pkg::SEQ_IDLE: begin
                    pulldown_q <= 1'b0;
                    bat_switch_open_req_q <= (mode_q == power_path_pkg::SUPPLY_FLOAT);
                    in_switch_open_req_q  <= (mode_q == power_path_pkg::SUPPLY_FLOAT);
                    if (pd_cond) begin
                        seq_q                 <= power_path_pkg::SEQ_OPEN;
                        bat_switch_open_req_q <= 1'b1;
                        in_switch_open_req_q  <= !ship_req;
                    end
                end
                power_path_pkg::SEQ_OPEN: begin
                    if (!pd_cond) begin
                        seq_q <= power_path_pkg::SEQ_IDLE;
                    end else if (ship_req && bat_switch_open) begin
                        seq_q      <= power_path_pkg::SEQ_PULL;
                        pulldown_q <= 1'b1;
                    end else if (bat_switch_open && in_switch_open) begin
                        seq_q      <= power_path_pkg::SEQ_PULL;
                        pulldown_q <= 1'b1;
                    end
                end
                power_path_pkg::SEQ_PULL: begin
                    // Reset pulldown outlives its request until the wake timer ends it.
                    // The requested switches stay open while here, so their state cannot gate the exit.
                    if (!ship_req && (mode_q != power_path_pkg::SUPPLY_PULLDOWN) &&
                        (wake_expired || (!hardware_reset_state_req && !reset_hold_q))) begin
                        seq_q      <= power_path_pkg::SEQ_IDLE;
                        pulldown_q <= 1'b0;
                    end
                end
                default: begin
                    seq_q <= power_path_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // A reset may be withdrawn before the wake timer ends, so its cause is remembered here.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reset_hold_q <= 1'b0;
        end else if (seq_q == power_path_pkg::SEQ_IDLE) begin
            reset_hold_q <= 1'b0;
        end else if (hardware_reset_state_req) begin
            reset_hold_q <= 1'b1;
        end
    end

    // Status flags: sticky, hardware set wins over a clearing write in the same cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vin_limit_flag_q <= 1'b0;
            input_current_limit_flag_q      <= 1'b0;
            input_current_limit_prev_q      <= 1'b0;
            input_current_limit_irq_q       <= 1'b0;
        end else begin
            input_current_limit_prev_q <= input_current_limit_clamp;
            if (vin_limit_on) begin
                vin_limit_flag_q <= 1'b1;
            end else if (wr && (addr == `PP_STAT_OFS) && wdata[0]) begin
                vin_limit_flag_q <= 1'b0;
            end
            if (input_current_limit_clamp) begin
                input_current_limit_flag_q <= 1'b1;
            end else if (wr && (addr == `PP_STAT_OFS) && wdata[1]) begin
                input_current_limit_flag_q <= 1'b0;
            end
            input_current_limit_irq_q <= input_current_limit_clamp && !input_current_limit_prev_q && !input_current_limit_mask_q;
        end
    end

    // Read data, registered; unmapped addresses read zero.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h0;
        end else if (rd) begin
            unique case (addr)
                `PP_CTRL_OFS: rdata <= {24'h0, input_current_limit_mask_q, dbl_tmr_q, head_dis_q, reg_target_q, mode_q};
                `PP_STAT_OFS: rdata <= {26'h0, pulldown_q, supplement_q, in_valid_q,
                                        sys_reg_en_q, input_current_limit_flag_q, vin_limit_flag_q};
                `PP_INPUT_CURRENT_LIMIT_OFS: rdata <= {24'h0, input_current_limit_code_q};
                default:      rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end

    // Guards.
    a_vin_limit_flag: assert property (@(posedge clk) disable iff (!rstn)
        vin_limit_on |=> vin_limit_flag_q && in_current_reduce_q)
        else $error("input limit flag not set");
    a_timer_extend: assert property (@(posedge clk) disable iff (!rstn)
        (dbl_tmr_q && vin_limit_on) |=> timer_extend_q)
        else $error("timer not extended");
    a_term_block: assert property (@(posedge clk) disable iff (!rstn)
        (vin_limit_on || head_on) |=> term_block_q)
        else $error("termination not blocked");
    a_supp_uvlo: assert property (@(posedge clk) disable iff (!rstn)
        supplement_q |-> $past(bat_above_uvlo))
        else $error("supplement below lockout");
    a_mode_reject: assert property (@(posedge clk) disable iff (!rstn)
        (ctrl_wr && !toggle_q && wdata[1:0] == 2'h1 && !bat_above_uvlo)
        |=> mode_q == power_path_pkg::SUPPLY_NORMAL)
        else $error("battery mode accepted below lockout");
    a_mode_toggle: assert property (@(posedge clk) disable iff (!rstn)
        toggle_q |=> mode_q == power_path_pkg::SUPPLY_NORMAL)
        else $error("toggle did not restore mode");
    a_pd_after_open: assert property (@(posedge clk) disable iff (!rstn)
        $rose(pulldown_q) |-> $past(bat_switch_open))
        else $error("pulldown before switch open");
    a_input_current_limit_flag: assert property (@(posedge clk) disable iff (!rstn)
        input_current_limit_clamp |=> input_current_limit_flag_q)
        else $error("current limit flag not set");
    a_input_current_limit_mask: assert property (@(posedge clk) disable iff (!rstn)
        input_current_limit_mask_q |=> !input_current_limit_irq_q)
        else $error("masked interrupt raised");
    a_reg_enable: assert property (@(posedge clk) disable iff (!rstn)
        sys_reg_en_q |-> $past(in_good))
        else $error("regulation without valid input");
    a_head_disable: assert property (@(posedge clk) disable iff (!rstn)
        (head_dis_q && (reg_target_q != 3'h0)) |=> !charge_cut_q)
        else $error("headroom cut despite disable");
    a_rail_off: assert property (@(posedge clk) disable iff (!rstn)
        ((mode_q == power_path_pkg::SUPPLY_FLOAT) || (mode_q == power_path_pkg::SUPPLY_PULLDOWN))
        |=> !sys_from_in_q && !sys_from_bat_q)
        else $error("rail fed while switched off");
    a_force_battery: assert property (@(posedge clk) disable iff (!rstn)
        (charging && (mode_q == power_path_pkg::SUPPLY_BATTERY)) |=> charge_stop_q && !sys_from_in_q)
        else $error("charging kept in battery mode");
    a_reset_hold: assert property (@(posedge clk) disable iff (!rstn)
        (pulldown_q && reset_hold_q && !wake_expired) |=> pulldown_q)
        else $error("reset pulldown dropped early");
    a_pd_mode_hold: assert property (@(posedge clk) disable iff (!rstn)
        (pulldown_q && (mode_q == power_path_pkg::SUPPLY_PULLDOWN)) |=> pulldown_q)
        else $error("pulldown dropped in pulldown mode");
endmodule : power_path_ctrl

// ==== test_power_path_ctrl.sv ====
// Purpose: Self-checking bench for the power path mode control block.
// Assumes: Debounce shortened to 4 cycles; inputs driven on the rising edge or 1 ns after it.
// Notes:   Loop cases run from a table; supply modes and pulldown are hand tests.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module test_power_path_ctrl;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0, rd = 1'b0;
    logic [31:0] rdata;
    logic        in_valid_raw = 1'b1, in_above_limit = 1'b1, in_above_bat = 1'b1, in_below_ovp = 1'b1;
    logic        sys_below_headroom = 1'b0, sys_below_supplement = 1'b0, bat_above_uvlo = 1'b1;
    logic        input_current_limit_clamp = 1'b0, charge_current_zero = 1'b0, charging = 1'b1, ship_req = 1'b0;
    logic        hardware_reset_state_req = 1'b0, wake_expired = 1'b0, bat_switch_open = 1'b0, in_switch_open = 1'b0;
    logic        in_current_reduce_q, charge_cut_q, term_block_q, timer_extend_q, supplement_q;
    logic        charge_stop_q, sys_from_in_q, sys_from_bat_q, bat_req_q, in_req_q, pulldown_q;
    logic        sys_reg_en_q, input_current_limit_irq_q;
    logic [2:0]  reg_target_q;
    logic [7:0]  input_current_limit_code_q;
    int          error_cnt = 0, tests_run = 0, n;
    logic [31:0] d;
    typedef struct { logic [5:0] i; logic [5:0] o; } row_t;
    row_t        rows [6] = '{'{6'b110001, 6'b100000}, '{6'b100001, 6'b111100}, '{6'b111001, 6'b101010},
                              '{6'b111111, 6'b101011}, '{6'b111110, 6'b101010}, '{6'b010001, 6'b000000}};

    power_path_ctrl #(.DGL_CYC(4)) DUT (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .in_valid_raw(in_valid_raw), .in_above_limit(in_above_limit), .in_above_bat(in_above_bat),
        .in_below_ovp(in_below_ovp), .sys_below_headroom(sys_below_headroom),
        .sys_below_supplement(sys_below_supplement), .bat_above_uvlo(bat_above_uvlo),
        .input_current_limit_clamp(input_current_limit_clamp), .charge_current_zero(charge_current_zero), .charging(charging),
        .ship_req(ship_req), .hardware_reset_state_req(hardware_reset_state_req), .wake_expired(wake_expired),
        .bat_switch_open(bat_switch_open), .in_switch_open(in_switch_open),
        .in_current_reduce_q(in_current_reduce_q), .charge_cut_q(charge_cut_q), .term_block_q(term_block_q),
        .timer_extend_q(timer_extend_q), .supplement_q(supplement_q), .charge_stop_q(charge_stop_q),
        .sys_from_in_q(sys_from_in_q), .sys_from_bat_q(sys_from_bat_q), .bat_switch_open_req_q(bat_req_q),
        .in_switch_open_req_q(in_req_q), .pulldown_q(pulldown_q), .sys_reg_en_q(sys_reg_en_q),
        .reg_target_q(reg_target_q), .input_current_limit_code_q(input_current_limit_code_q), .input_current_limit_irq_q(input_current_limit_irq_q));

    // The clock toggles every half period of 10 ns.
    initial begin
        forever #5 clk = ~clk;
    end

    // Each bus task starts on a fresh edge, so a strobe is never set twice in one step.
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : settle

    // Bounded wait for the pulldown to reach a level; a miss shows up as a mismatch.
    task automatic wait_pd(input logic v, input int c);
        for (int k = 0; k < c && pulldown_q !== v; k++) settle(1);
    endtask : wait_pd

    // Input low then valid again, each well beyond the debounce span.
    task automatic toggle_in();
        @(posedge clk);
        in_valid_raw <= 1'b0;
        settle(10);
        in_valid_raw <= 1'b1;
        settle(12);
    endtask : toggle_in

    task automatic count_irq();
        n = 0;
        repeat (6) begin
            settle(1);
            if (input_current_limit_irq_q === 1'b1) n++;
        end
    endtask : count_irq

    // Reset is held for two cycles; reset values are checked while it is held.
    task automatic reset_dut();
        @(posedge clk);
        {ship_req, hardware_reset_state_req, bat_switch_open, in_switch_open, wake_expired} <= 5'h00;
        rstn <= 1'b0;
        settle(2);
        `CHK(reg_target_q, 3'h2)
        `CHK(pulldown_q, 1'b0)
        rstn <= 1'b1;
        settle(10);
    endtask : reset_dut

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    // The whole run needs well under two thousand cycles.
    initial begin
        #200000;
        error_cnt++;
        conclude();
    end

    // Main sequence: target sweep and table of loop cases first, then headroom, current limit, modes, pulldown and reset cases.
    initial begin
        reset_dut();
        rd_reg(8'h00, d);
        `CHK(d, 32'h08)
        `CHK(sys_from_in_q, 1'b1)
        for (int i = 0; i < 8; i++) begin
            wr_reg(8'h00, 32'(i) << 2);
            settle(2);
            `CHK(reg_target_q, 3'(i))
        end
        wr_reg(8'h00, 32'h48);
        foreach (rows[r]) begin
            {in_below_ovp, in_above_limit, sys_below_headroom, sys_below_supplement,
             charge_current_zero, bat_above_uvlo} <= rows[r].i;
            settle(3);
            `CHK({sys_reg_en_q, in_current_reduce_q, term_block_q, timer_extend_q, charge_cut_q, supplement_q}, rows[r].o)
        end
        // Headroom disable holds off the cut except in battery tracking.
        sys_below_headroom <= 1'b1;
        wr_reg(8'h00, 32'h28);
        settle(3);
        `CHK(charge_cut_q, 1'b0)
        wr_reg(8'h00, 32'h20);
        settle(3);
        `CHK(charge_cut_q, 1'b1)
        {in_below_ovp, in_above_limit, sys_below_headroom, sys_below_supplement,
         charge_current_zero, bat_above_uvlo} <= rows[0].i;
        rd_reg(8'h04, d);
        `CHK(d[0], 1'b1)
        // Clamp rise: unmasked gives one pulse, masked gives none but still flags.
        input_current_limit_clamp <= 1'b1;
        count_irq();
        `CHK(n, 1)
        input_current_limit_clamp <= 1'b0;
        wr_reg(8'h04, 32'h3);
        rd_reg(8'h04, d);
        `CHK(d[1:0], 2'h0)
        wr_reg(8'h00, 32'h88);
        wr_reg(8'h08, 32'h5a);
        input_current_limit_clamp <= 1'b1;
        count_irq();
        `CHK(n, 0)
        `CHK(input_current_limit_code_q, 8'h5a)
        rd_reg(8'h04, d);
        `CHK(d[1], 1'b1)
        input_current_limit_clamp <= 1'b0;
        rd_reg(8'h10, d);
        `CHK(d, 32'h0)
        // Force-battery write with a flat battery must fall back to normal.
        bat_above_uvlo <= 1'b0;
        wr_reg(8'h00, 32'h09);
        rd_reg(8'h00, d);
        `CHK(d[1:0], 2'h0)
        bat_above_uvlo <= 1'b1;
        wr_reg(8'h00, 32'h09);
        settle(3);
        `CHK({charge_stop_q, sys_from_bat_q, sys_from_in_q}, 3'b110)
        toggle_in();
        rd_reg(8'h00, d);
        `CHK(d[1:0], 2'h0)
        wr_reg(8'h00, 32'h0a);
        settle(3);
        `CHK({sys_from_bat_q, sys_from_in_q, pulldown_q}, 3'b000)
        toggle_in();
        rd_reg(8'h00, d);
        `CHK(d[1:0], 2'h0)
        // Pulldown mode: both switches must open before the pulldown engages.
        wr_reg(8'h00, 32'h0b);
        settle(3);
        `CHK({bat_req_q, in_req_q, pulldown_q}, 3'b110)
        {bat_switch_open, in_switch_open} <= 2'b11;
        wait_pd(1'b1, 5);
        settle(5);
        `CHK(pulldown_q, 1'b1)
        toggle_in();
        rd_reg(8'h00, d);
        `CHK(d[1:0], 2'h0)
        wait_pd(1'b0, 10);
        `CHK(pulldown_q, 1'b0)
        {bat_switch_open, in_switch_open} <= 2'b00;
        // Ship mode waits for the battery switch only.
        ship_req <= 1'b1;
        settle(4);
        `CHK(pulldown_q, 1'b0)
        bat_switch_open <= 1'b1;
        wait_pd(1'b1, 5);
        `CHK(pulldown_q, 1'b1)
        reset_dut();
        hardware_reset_state_req <= 1'b1;
        settle(4);
        `CHK(pulldown_q, 1'b0)
        {bat_switch_open, in_switch_open} <= 2'b11;
        wait_pd(1'b1, 5);
        settle(10);
        `CHK(pulldown_q, 1'b1)
        hardware_reset_state_req <= 1'b0;
        settle(3);
        `CHK(pulldown_q, 1'b1)
        wake_expired <= 1'b1;
        wait_pd(1'b0, 5);
        `CHK(pulldown_q, 1'b0)
        conclude();
    end
endmodule : test_power_path_ctrl
